//--- inc/hawt_params.svh
// Constants for the halt auto-wakeup timer
`ifndef HAWT_PARAMS_SVH
`define HAWT_PARAMS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define HAWT_ADDR_PRESC     8'h49
`define HAWT_ADDR_CSR       8'h4A
`define HAWT_ADDR_IRQ_STAT  8'h4B
`define HAWT_ADDR_IRQ_MASK  8'h4C

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define HAWT_CSR_EN_BIT     0
`define HAWT_CSR_MEAS_BIT   1
`define HAWT_CSR_FLAG_BIT   2
`define HAWT_CSR_RST        3'h0
`define HAWT_PRESC_RST      8'hFF
`define HAWT_PRESC_FORBID   8'h00
`define HAWT_IRQ_RST        3'h0
`define HAWT_EV_TIMED       0
`define HAWT_EV_EXIT        1
`define HAWT_EV_WDG         2
`define HAWT_BYTE_ZERO      8'h00

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define HAWT_FIX_DIV        64
`define HAWT_FIX_LAST       6'h3F
`define HAWT_CLK_MHZ        125
`define HAWT_RC_STARTUP_NS  10000
`define HAWT_RC_STARTUP_CYC \
   ((`HAWT_RC_STARTUP_NS * `HAWT_CLK_MHZ + 999) / 1000)
`define HAWT_STAB_SHORT     256
`define HAWT_STAB_LONG      512
`define HAWT_CNT_ZERO       11'h000

`endif

//--- inc/hawt_pkg.sv
// Types for the halt auto-wakeup timer
package hawt_pkg;

   // -------------------------------------------------------------
   // Power state
   // -------------------------------------------------------------
   typedef enum logic [4:0] {
      ST_RUN      = 5'h01,
      ST_HALT     = 5'h02,
      ST_RC_START = 5'h04,
      ST_COUNT    = 5'h08,
      ST_STAB     = 5'h10
   } hawt_state_e;

   // -------------------------------------------------------------
   // Control/status register content
   // -------------------------------------------------------------
   typedef struct packed {
      logic flag;
      logic measure;
      logic enable;
   } hawt_csr_s;

   typedef logic [10:0] hawt_cnt_t;

endpackage : hawt_pkg

//--- logic/hawt_div.sv
// Fixed divide-by-64 followed by the programmable prescaler
`timescale 1ns/10ps
`include "hawt_params.svh"

module hawt_div
   import hawt_pkg::*;
(
   // Clock and reset
   input  wire logic       clk_in,
   input  wire logic       rst_n_in,
   // Control
   input  wire logic       clear_in,
   input  wire logic       run_in,
   input  wire logic       tick_in,
   input  wire logic [7:0] presc_in,
   // Result
   output logic            done_out
);

   logic [5:0] fix_q;
   logic [7:0] pre_q;
   logic       done_q;

   function automatic logic [7:0] inc8(input logic [7:0] v);
      inc8 = v + 8'h01;
   endfunction : inc8

   wire       step_w    = run_in & tick_in;
   wire       fix_wrap_w = step_w & (fix_q == `HAWT_FIX_LAST);
   wire       pre_hit_w = fix_wrap_w & (inc8(pre_q) == presc_in);

   // ----------------------------------------------------------------
   // Counters
   // ----------------------------------------------------------------
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         fix_q  <= 6'h00;
         pre_q  <= 8'h00;
         done_q <= 1'b0;
      end else if (clear_in) begin
         fix_q  <= 6'h00;
         pre_q  <= 8'h00;
         done_q <= 1'b0;
      end else begin
         done_q <= pre_hit_w;
         if (step_w) begin
            fix_q <= fix_q + 6'h01;
         end
         if (fix_wrap_w) begin
            pre_q <= pre_hit_w ? 8'h00 : inc8(pre_q);
         end
      end
   end

   assign done_out = done_q;

endmodule : hawt_div

//--- logic/hawt_top.sv
// Halt auto-wakeup timer: power state, registers and wake logic
// What this block does
// - Halt with enable set enters timed halt
// - Wake RC oscillator replaces main clock
// - Delay is 64 times prescaler plus startup
// - Timeout sets flag and raises wake interrupt
// - Wake turns main oscillator on, 256/512 wait
// - Reading control/status clears flag and wake interrupt
// - Writes to flag bit are ignored
// - Measure bit routes RC clock to capture
// - Control/status resets to 00h, 7:3 zero
// - Prescaler resets FFh, value is divide factor
// - Halt entry forces CPU interrupt mask clear
// - Timed halt stops main oscillator, peripherals
// - Reset or halt-exit interrupt also wakes
// - Watchdog halt option selects watchdog reset
`timescale 1ns/10ps
`include "hawt_params.svh"

module hawt_top
   import hawt_pkg::*;
(
   // Clock and reset
   input  wire logic       clk_in,
   input  wire logic       rst_n_in,
   // Register port
   input  wire logic [7:0] addr_in,
   input  wire logic [7:0] wdata_in,
   input  wire logic       wr_in,
   input  wire logic       rd_in,
   output logic [7:0]      rdata_out,
   // CPU and power control
   input  wire logic       halt_exec_in,
   input  wire logic       exit_irq_in,
   input  wire logic       stab_long_in,
   input  wire logic       wdg_enabled_in,
   input  wire logic       watchdog_in_halt_option_in,
   output logic            imask_clear_out,
   output logic            wdg_reset_out,
   output logic            cpu_stall_out,
   output logic            periph_stop_out,
   // Oscillators
   input  wire logic       rc_clk_in,
   output logic            main_osc_on_out,
   output logic            rc_osc_en_out,
   output logic            clk_sel_rc_out,
   // Lite timer capture
   output logic            lt_capture_out,
   // Interrupts
   output logic            wake_irq_out,
   output logic            irq_out
);

   // ----------------------------------------------------------------
   // State and registers
   // ----------------------------------------------------------------
   hawt_state_e state_q;
   hawt_state_e state_d;
   hawt_csr_s   csr_q;
   hawt_csr_s   csr_d;
   logic [7:0]  presc_q;
   logic [2:0]  stat_q;
   logic [2:0]  stat_d;
   logic [2:0]  mask_q;
   logic [7:0]  rdata_q;
   hawt_cnt_t   cnt_q;
   hawt_cnt_t   cnt_d;
   logic        imask_q;
   logic        wdg_q;
   logic        irq_q;
   logic        rc_s1_q;
   logic        rc_s2_q;
   logic        rc_s3_q;
   logic        div_done;

   // ----------------------------------------------------------------
   // Register decode
   // ----------------------------------------------------------------
   wire sel_presc_w = (addr_in == `HAWT_ADDR_PRESC);
   wire sel_csr_w   = (addr_in == `HAWT_ADDR_CSR);
   wire sel_stat_w  = (addr_in == `HAWT_ADDR_IRQ_STAT);
   wire sel_mask_w  = (addr_in == `HAWT_ADDR_IRQ_MASK);

   wire wr_presc_w  = wr_in & sel_presc_w;
   wire wr_csr_w    = wr_in & sel_csr_w;
   wire wr_stat_w   = wr_in & sel_stat_w;
   wire wr_mask_w   = wr_in & sel_mask_w;
   wire rd_csr_w    = rd_in & sel_csr_w;

   wire presc_ok_w  = (wdata_in != `HAWT_PRESC_FORBID);

   wire [7:0] csr_rd_w = {5'h00, csr_q};

   wire [7:0] rd_mux_w =
      sel_presc_w ? presc_q :
      sel_csr_w   ? csr_rd_w :
      sel_stat_w  ? {5'h00, stat_q} :
      sel_mask_w  ? {5'h00, mask_q} :
                    `HAWT_BYTE_ZERO;

   // ----------------------------------------------------------------
   // State decode
   // ----------------------------------------------------------------
   wire in_run_w    = (state_q == ST_RUN);
   wire in_halt_w   = (state_q == ST_HALT);
   wire in_start_w  = (state_q == ST_RC_START);
   wire in_count_w  = (state_q == ST_COUNT);
   wire in_stab_w   = (state_q == ST_STAB);
   wire in_timed_w  = in_start_w | in_count_w;
   wire halted_w    = in_halt_w | in_timed_w;
   wire cnt_zero_w  = (cnt_q == `HAWT_CNT_ZERO);

   // ----------------------------------------------------------------
   // Halt entry and events
   // ----------------------------------------------------------------
   wire wdg_trip_w  = in_run_w & halt_exec_in & wdg_enabled_in
                      & watchdog_in_halt_option_in;
   wire halt_go_w   = in_run_w & halt_exec_in & ~wdg_trip_w;
   wire timed_ev_w  = in_count_w & div_done & ~exit_irq_in;
   wire exit_ev_w   = halted_w & exit_irq_in;

   wire [2:0] ev_w;
   assign ev_w[`HAWT_EV_TIMED] = timed_ev_w;
   assign ev_w[`HAWT_EV_EXIT]  = exit_ev_w;
   assign ev_w[`HAWT_EV_WDG]   = wdg_trip_w;

   wire [2:0] stat_clr_w = wr_stat_w ? wdata_in[2:0] : 3'h0;

   // ----------------------------------------------------------------
   // Counter reload values
   // ----------------------------------------------------------------
   wire hawt_cnt_t startup_w = hawt_cnt_t'(`HAWT_RC_STARTUP_CYC - 1);
   wire hawt_cnt_t stab_w    = stab_long_in
                             ? hawt_cnt_t'(`HAWT_STAB_LONG - 1)
                             : hawt_cnt_t'(`HAWT_STAB_SHORT - 1);

   // ----------------------------------------------------------------
   // Wake RC clock synchroniser
   // ----------------------------------------------------------------
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rc_s1_q <= 1'b0;
         rc_s2_q <= 1'b0;
         rc_s3_q <= 1'b0;
      end else begin
         rc_s1_q <= rc_clk_in;
         rc_s2_q <= rc_s1_q;
         rc_s3_q <= rc_s2_q;
      end
   end

   wire rc_tick_w = rc_s2_q & ~rc_s3_q;

   // ----------------------------------------------------------------
   // Delay divider
   // ----------------------------------------------------------------
   hawt_div u_div (
      .clk_in   (clk_in),
      .rst_n_in (rst_n_in),
      .clear_in (~in_count_w),
      .run_in   (in_count_w & ~csr_q.flag),
      .tick_in  (rc_tick_w),
      .presc_in (presc_q),
      .done_out (div_done)
   );

   // ----------------------------------------------------------------
   // Power state machine
   // ----------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q;
      case (state_q)
         ST_RUN: begin
            if (halt_go_w) begin
               if (csr_q.enable) begin
                  state_d = ST_RC_START;
                  cnt_d   = startup_w;
               end else begin
                  state_d = ST_HALT;
               end
            end
         end
         ST_HALT: begin
            if (exit_irq_in) begin
               state_d = ST_STAB;
               cnt_d   = stab_w;
            end
         end
         ST_RC_START: begin
            if (exit_irq_in) begin
               state_d = ST_STAB;
               cnt_d   = stab_w;
            end else if (cnt_zero_w) begin
               state_d = ST_COUNT;
            end else begin
               cnt_d = cnt_q - 11'h001;
            end
         end
         ST_COUNT: begin
            if (exit_irq_in || div_done) begin
               state_d = ST_STAB;
               cnt_d   = stab_w;
            end
         end
         ST_STAB: begin
            if (cnt_zero_w) begin
               state_d = ST_RUN;
            end else begin
               cnt_d = cnt_q - 11'h001;
            end
         end
         default: begin
            state_d = ST_RUN;
            cnt_d   = `HAWT_CNT_ZERO;
         end
      endcase
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_q <= ST_RUN;
         cnt_q   <= `HAWT_CNT_ZERO;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
      end
   end

   // ----------------------------------------------------------------
   // Control/status and prescaler registers
   // ----------------------------------------------------------------
   always_comb begin
      csr_d = csr_q;
      if (wr_csr_w) begin
         csr_d.measure = wdata_in[`HAWT_CSR_MEAS_BIT];
         csr_d.enable  = wdata_in[`HAWT_CSR_EN_BIT];
      end
      csr_d.flag = timed_ev_w | (csr_q.flag & ~rd_csr_w);
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         csr_q   <= `HAWT_CSR_RST;
         presc_q <= `HAWT_PRESC_RST;
      end else begin
         csr_q <= csr_d;
         if (wr_presc_w && presc_ok_w) begin
            presc_q <= wdata_in;
         end
      end
   end

   // ----------------------------------------------------------------
   // Interrupt status and mask
   // ----------------------------------------------------------------
   assign stat_d = (stat_q & ~stat_clr_w) | ev_w;

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         stat_q <= `HAWT_IRQ_RST;
         mask_q <= `HAWT_IRQ_RST;
         irq_q  <= 1'b0;
      end else begin
         stat_q <= stat_d;
         if (wr_mask_w) begin
            mask_q <= wdata_in[2:0];
         end
         irq_q <= |(stat_q & mask_q);
      end
   end

   // ----------------------------------------------------------------
   // Read data and CPU pulses
   // ----------------------------------------------------------------
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rdata_q <= `HAWT_BYTE_ZERO;
         imask_q <= 1'b0;
         wdg_q   <= 1'b0;
      end else begin
         rdata_q <= rd_in ? rd_mux_w : `HAWT_BYTE_ZERO;
         imask_q <= halt_go_w;
         wdg_q   <= wdg_trip_w;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign rdata_out       = rdata_q;
   assign imask_clear_out = imask_q;
   assign wdg_reset_out   = wdg_q;
   assign cpu_stall_out   = halted_w | in_stab_w;
   assign periph_stop_out = halted_w;
   assign main_osc_on_out = in_run_w | in_stab_w;
   assign clk_sel_rc_out  = in_timed_w;
   assign rc_osc_en_out   = in_timed_w | csr_q.measure;
   assign lt_capture_out  = csr_q.measure & rc_s2_q;
   assign wake_irq_out    = csr_q.flag;
   assign irq_out         = irq_q;

endmodule : hawt_top

//--- tb/hawt_top_asserts.sv
// Port checker for the halt auto-wakeup timer
`timescale 1ns/10ps

module hawt_top_asserts (
   // Clock and reset
   input wire logic       clk_in,
   input wire logic       rst_n_in,
   // Watched inputs
   input wire logic [7:0] addr_in,
   input wire logic       rd_in,
   input wire logic       halt_exec_in,
   input wire logic       exit_irq_in,
   input wire logic       wdg_enabled_in,
   input wire logic       watchdog_in_halt_option_in,
   // Watched outputs
   input wire logic [7:0] rdata_out,
   input wire logic       imask_clear_out,
   input wire logic       wdg_reset_out,
   input wire logic       cpu_stall_out,
   input wire logic       periph_stop_out,
   input wire logic       main_osc_on_out,
   input wire logic       rc_osc_en_out,
   input wire logic       clk_sel_rc_out,
   input wire logic       lt_capture_out,
   input wire logic       wake_irq_out
);
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rst_n_in);

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   AST_RD_IDLE: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
      else $error("read data not zero");
   AST_CSR_RSVD: assert property (
      $past(rd_in) && $past(addr_in) == 8'h4A |-> rdata_out[7:3] == 5'h00)
      else $error("reserved bits set");
   AST_HALT_TAKE: assert property (
      halt_exec_in && !cpu_stall_out
      && !(wdg_enabled_in && watchdog_in_halt_option_in) |=> cpu_stall_out)
      else $error("halt not entered");
   AST_WDG: assert property (
      halt_exec_in && !cpu_stall_out && wdg_enabled_in
      && watchdog_in_halt_option_in |=> wdg_reset_out && !cpu_stall_out)
      else $error("watchdog reset missing");
   AST_IMASK: assert property ($rose(cpu_stall_out) |-> imask_clear_out)
      else $error("mask clear missing");
   AST_OSC_OFF: assert property (
      periph_stop_out |-> !main_osc_on_out && cpu_stall_out)
      else $error("main oscillator on in halt");
   AST_CLKSEL: assert property (
      clk_sel_rc_out |-> rc_osc_en_out && periph_stop_out)
      else $error("rc clock selected while off");
   AST_EXIT: assert property (
      exit_irq_in && periph_stop_out |=> main_osc_on_out && cpu_stall_out)
      else $error("exit interrupt did not wake");
   AST_WAKE: assert property (
      $rose(wake_irq_out) |-> $past(clk_sel_rc_out) && main_osc_on_out)
      else $error("wake flag out of place");
   AST_CAPT: assert property (
      $rose(lt_capture_out) |-> $past(rc_osc_en_out, 2))
      else $error("capture without rc clock");
   AST_FLAG_CLR: assert property (
      rd_in && addr_in == 8'h4A && wake_irq_out && !clk_sel_rc_out
      |=> !wake_irq_out)
      else $error("flag not cleared by read");

   cover property ($rose(wake_irq_out));
   cover property (wdg_reset_out);
   cover property ($rose(lt_capture_out));
endmodule : hawt_top_asserts

bind hawt_top hawt_top_asserts u_asserts (.clk_in, .rst_n_in, .addr_in,
   .rd_in, .halt_exec_in, .exit_irq_in, .wdg_enabled_in,
   .watchdog_in_halt_option_in, .rdata_out, .imask_clear_out,
   .wdg_reset_out, .cpu_stall_out, .periph_stop_out, .main_osc_on_out,
   .rc_osc_en_out, .clk_sel_rc_out, .lt_capture_out, .wake_irq_out);

//--- tb/hawt_far_model.sv
// Far-side model: wake RC oscillator and CPU interrupt mask
`timescale 1ns/10ps

module hawt_far_model #(
   parameter real HALF_NS = 16.3
) (
   // From the timer
   input  wire logic clk_in,
   input  wire logic rc_osc_en_in,
   input  wire logic imask_clear_in,
   // Model outputs
   output logic      rc_clk_out,
   output logic      cpu_imask_out
);
   // RC runs only while enabled and rests low otherwise
   initial rc_clk_out = 1'b0;
   always begin
      if (rc_osc_en_in === 1'b1) begin
         #(HALF_NS);
         rc_clk_out = ~rc_clk_out & rc_osc_en_in;
      end else begin
         rc_clk_out = 1'b0;
         @(rc_osc_en_in);
      end
   end

   // CPU mask bit, forced clear on halt entry
   initial cpu_imask_out = 1'b1;
   always @(posedge clk_in) begin
      if (imask_clear_in) cpu_imask_out <= 1'b0;
   end
endmodule : hawt_far_model

//--- tb/hawt_tb.sv
// Self-checking testbench for the halt auto-wakeup timer
`timescale 1ns/10ps
`include "hawt_params.svh"

module tb;
   logic       clk_in = 1'b0, rst_n_in = 1'b0;
   logic [7:0] addr_in = 8'h00, wdata_in = 8'h00, rdata_out, v;
   logic       wr_in = 0, rd_in = 0, halt_exec_in = 0, exit_irq_in = 0;
   logic       stab_long_in = 0, wdg_enabled_in = 0;
   logic       watchdog_in_halt_option_in = 0, rc_clk_in, cpu_imask;
   logic       imask_clear_out, wdg_reset_out, cpu_stall_out;
   logic       periph_stop_out, main_osc_on_out, rc_osc_en_out;
   logic       clk_sel_rc_out, lt_capture_out, wake_irq_out, irq_out;
   logic       rd_pend = 1'b0, capt_seen = 1'b0;
   logic [7:0] exp_q[$];
   logic [15:0] seed = 16'd38028;
   int         mismatches = 0, samples_checked = 0, n, lo;

   hawt_top DUT (.clk_in, .rst_n_in, .addr_in, .wdata_in, .wr_in, .rd_in,
      .rdata_out, .halt_exec_in, .exit_irq_in, .stab_long_in,
      .wdg_enabled_in, .watchdog_in_halt_option_in, .imask_clear_out,
      .wdg_reset_out, .cpu_stall_out, .periph_stop_out, .rc_clk_in,
      .main_osc_on_out, .rc_osc_en_out, .clk_sel_rc_out, .lt_capture_out,
      .wake_irq_out, .irq_out);
   hawt_far_model u_far (.clk_in, .rc_osc_en_in(rc_osc_en_out),
      .imask_clear_in(imask_clear_out), .rc_clk_out(rc_clk_in),
      .cpu_imask_out(cpu_imask));

   always #4 clk_in = ~clk_in;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [15:0] xs(input logic [15:0] s);
      s ^= s << 7;
      s ^= s >> 9;
      s ^= s << 8;
      return s;
   endfunction : xs

   task automatic summarize;
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : summarize

   task automatic chk(input string nm, input logic [15:0] e, g);
      samples_checked++;
      if (g !== e) begin
         mismatches++;
         $display("unexpected %s exp %0h got %0h", nm, e, g);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, d);
      @(posedge clk_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge clk_in);
      wr_in <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, e);
      exp_q.push_back(e);
      @(posedge clk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge clk_in);
      rd_in <= 1'b0;
   endtask : rd

   task automatic halt;
      @(posedge clk_in);
      halt_exec_in <= 1'b1;
      @(posedge clk_in);
      halt_exec_in <= 1'b0;
      @(negedge clk_in);
   endtask : halt

   task automatic stab_len(input int e);
      for (n = 0; n < 2000 && cpu_stall_out !== 1'b0; n++) @(negedge clk_in);
      chk("stab_len", 1'b1, n >= e - 2 && n <= e + 2);
   endtask : stab_len

   // Read data monitor takes the oldest expectation
   always @(posedge clk_in) rd_pend <= rd_in;
   always @(negedge clk_in) begin
      if (rd_pend) chk("rdata", exp_q.pop_front(), rdata_out);
   end
   always @(posedge lt_capture_out) capt_seen = 1'b1;

   initial begin
      repeat (20000) @(posedge clk_in);
      mismatches++;
      summarize();
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (10) @(posedge clk_in);
      rst_n_in <= 1'b1;
      rd(`HAWT_ADDR_PRESC, `HAWT_PRESC_RST);
      rd(`HAWT_ADDR_CSR, 8'h00);
      rd(8'h50, 8'h00);
      wr(`HAWT_ADDR_CSR, 8'hFF);
      rd(`HAWT_ADDR_CSR, 8'h03);
      wr(`HAWT_ADDR_PRESC, `HAWT_PRESC_FORBID);
      rd(`HAWT_ADDR_PRESC, 8'hFF);
      for (int i = 0; i < 6; i++) begin
         seed = xs(seed);
         v = (seed[7:0] == 8'h00) ? 8'h01 : seed[7:0];
         wr(`HAWT_ADDR_PRESC, v);
         rd(`HAWT_ADDR_PRESC, v);
      end
      repeat (20) @(negedge clk_in);
      chk("rc_en", 1'b1, rc_osc_en_out);
      chk("capture", 1'b1, capt_seen);
      // Timed halt with prescaler 2
      wr(`HAWT_ADDR_CSR, 8'h01);
      wr(`HAWT_ADDR_PRESC, 8'h02);
      wr(`HAWT_ADDR_IRQ_MASK, 8'h01);
      halt();
      chk("clk_sel", 1'b1, clk_sel_rc_out);
      chk("main_osc", 1'b0, main_osc_on_out);
      chk("periph", 1'b1, periph_stop_out);
      chk("imask", 1'b1, imask_clear_out);
      lo = `HAWT_RC_STARTUP_CYC + (128 * 326) / 80;
      for (n = 0; n < 4000 && wake_irq_out !== 1'b1; n++) @(negedge clk_in);
      chk("wake_dly", 1'b1, n >= lo - 5 && n <= lo + 9);
      chk("osc_on", 1'b1, main_osc_on_out);
      stab_len(256);
      chk("irq", 1'b1, irq_out);
      chk("cpu_mask", 1'b0, cpu_imask);
      rd(`HAWT_ADDR_CSR, 8'h05);
      @(negedge clk_in);
      chk("flag_clr", 1'b0, wake_irq_out);
      rd(`HAWT_ADDR_IRQ_STAT, 8'h01);
      wr(`HAWT_ADDR_IRQ_STAT, 8'h01);
      repeat (2) @(negedge clk_in);
      chk("irq_clr", 1'b0, irq_out);
      // Plain halt left by an exit interrupt, long stabilisation
      wr(`HAWT_ADDR_CSR, 8'h00);
      stab_long_in <= 1'b1;
      halt();
      chk("clk_sel", 1'b0, clk_sel_rc_out);
      chk("stall", 1'b1, cpu_stall_out);
      @(posedge clk_in);
      exit_irq_in <= 1'b1;
      @(posedge clk_in);
      exit_irq_in <= 1'b0;
      @(negedge clk_in);
      chk("exit_wake", 1'b1, main_osc_on_out);
      stab_len(512);
      rd(`HAWT_ADDR_IRQ_STAT, 8'h02);
      @(negedge clk_in);
      chk("irq_mask", 1'b0, irq_out);
      wr(`HAWT_ADDR_IRQ_STAT, 8'h07);
      // Watchdog option, then a pending interrupt at entry
      wdg_enabled_in <= 1'b1;
      watchdog_in_halt_option_in <= 1'b1;
      halt();
      chk("wdg_rst", 1'b1, wdg_reset_out);
      chk("wdg_run", 1'b0, cpu_stall_out);
      @(posedge clk_in);
      watchdog_in_halt_option_in <= 1'b0;
      exit_irq_in <= 1'b1;
      halt();
      @(negedge clk_in);
      chk("pend_wake", 1'b1, main_osc_on_out & cpu_stall_out);
      @(posedge clk_in);
      exit_irq_in <= 1'b0;
      stab_len(510);
      rd(`HAWT_ADDR_IRQ_STAT, 8'h06);
      repeat (2) @(negedge clk_in);
      summarize();
   end
endmodule : tb
